// [include/port_ctl_pkg.sv]
// constants and types for the per-port ownership, power and test logic
// ---------------------------------------------------------------------
// Behaviour
// R1 - test select zero is normal; one, two, three pick J, K, SE0-NAK tests
// R2 - test select four picks test packet, five picks forced enable
// R3 - test select six to fifteen reserved; no test behaviour given them
// R4 - owner bit resets to one and is held one while configure flag is zero
// R5 - configure flag rising edge clears owner bit unconditionally
// R6 - owner bit one hands port to companion; enhanced side stops driving
// R7 - software sets owner bit for devices that are not high-speed
// R8 - without power switches the power bit reads one, port always powered
// R9 - with power switches the power bit drives the switch, one means on
// R10 - unpowered port is nonfunctional and reports no status changes
// R11 - overcurrent on powered switched port clears its power bit
// R12 - line state bit 11 shows positive line, bit 10 negative line
// R13 - line state valid only when disabled and connected; undefined unpowered
// R14 - software treats K-state line value as low-speed and releases port
// R15 - software treats SE0, J or 11 line values as not low-speed, resets
// R16 - software writes reserved bits as zero
// ---------------------------------------------------------------------
package port_ctl_pkg;
   // ------------------------------------------------------------------
   // field positions of the port status and control register
   // ------------------------------------------------------------------
   localparam int TEST_LSB = 16;
   localparam int TEST_MSB = 19;
   localparam int OWNER_BIT = 13;
   localparam int POWER_BIT = 12;
   localparam int LINE_DP_BIT = 11;
   localparam int LINE_DM_BIT = 10;
   localparam int ENABLE_BIT = 2;
   localparam int CONNECT_BIT = 0;
   // reset values
   localparam logic OWNER_RESET = 1'b1;
   localparam logic POWER_RESET = 1'b0;
   localparam logic [3:0] TEST_RESET = 4'h0;
   // test select codes
   localparam logic [3:0] TEST_OFF = 4'h0;
   localparam logic [3:0] TEST_J = 4'h1;
   localparam logic [3:0] TEST_K = 4'h2;
   localparam logic [3:0] TEST_SE0_NAK = 4'h3;
   localparam logic [3:0] TEST_PACKET = 4'h4;
   localparam logic [3:0] TEST_FORCE_EN = 4'h5;
   // line state encodings
   localparam logic [1:0] LINE_SE0 = 2'h0;
   localparam logic [1:0] LINE_K = 2'h1;
   localparam logic [1:0] LINE_J = 2'h2;

   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_J,
      MODE_K,
      MODE_SE0_NAK,
      MODE_PACKET,
      MODE_FORCE_EN
   } test_mode_type;

   // software write bundle for the port register
   typedef struct packed {
      logic wr;
      logic [31:0] data;
   } reg_write_type;

   // state of the port exported to the transceiver side
   typedef struct packed {
      logic owned_by_companion;
      logic power_on;
      logic drive_enable;
      test_mode_type test_mode;
   } port_drive_type;
endpackage

// [design/test_mode_decode.sv]
// decoder from the test select field to the test mode in force
`timescale 1ns/1ps
module test_mode_decode (
   input wire logic [3:0] sel_i,
   output port_ctl_pkg::test_mode_type mode_o,
   output logic reserved_o
);
   // reserved codes fall back to normal operation
   always_comb begin
      reserved_o = 1'b0;
      unique case (sel_i)
         port_ctl_pkg::TEST_OFF: mode_o = port_ctl_pkg::MODE_NORMAL; // R1
         port_ctl_pkg::TEST_J: mode_o = port_ctl_pkg::MODE_J; // R1
         port_ctl_pkg::TEST_K: mode_o = port_ctl_pkg::MODE_K; // R1
         port_ctl_pkg::TEST_SE0_NAK: mode_o = port_ctl_pkg::MODE_SE0_NAK; // R1
         port_ctl_pkg::TEST_PACKET: mode_o = port_ctl_pkg::MODE_PACKET; // R2
         port_ctl_pkg::TEST_FORCE_EN: mode_o = port_ctl_pkg::MODE_FORCE_EN; // R2
         default: begin
            mode_o = port_ctl_pkg::MODE_NORMAL; // R3
            reserved_o = 1'b1; // R3
         end
      endcase
   end
endmodule

// [design/port_owner_power.sv]
// per-port ownership hand-off, power switch and line state logic
`timescale 1ns/1ps
module port_owner_power #(
   parameter bit POWER_SWITCHES = 1'b1
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire port_ctl_pkg::reg_write_type reg_wr_i,
   output logic [31:0] reg_rd_o,
   input wire logic configure_flag_i,
   input wire logic overcurrent_i,
   input wire logic line_dp_i,
   input wire logic line_dm_i,
   input wire logic port_enabled_i,
   input wire logic connected_i,
   output port_ctl_pkg::port_drive_type drive_o,
   output logic power_switch_o,
   output logic status_gate_o,
   output logic test_reserved_o
);
   // ------------------------------------------------------------------
   // elaboration checks; the read image is one 32-bit word
   // ------------------------------------------------------------------
   if (port_ctl_pkg::TEST_MSB - port_ctl_pkg::TEST_LSB != 3) begin : g_test_width
      $error("test select field must span four bits");
   end
   if (port_ctl_pkg::TEST_MSB > 31) begin : g_test_place
      $error("test select field lies outside the port word");
   end
   if (port_ctl_pkg::LINE_DP_BIT != port_ctl_pkg::LINE_DM_BIT + 1) begin : g_line_place
      $error("line state bits must be adjacent");
   end
   if (port_ctl_pkg::OWNER_BIT == port_ctl_pkg::POWER_BIT) begin : g_owner_place
      $error("owner and power bits must differ");
   end
   if (port_ctl_pkg::OWNER_BIT > 31 || port_ctl_pkg::POWER_BIT > 31) begin : g_bit_place
      $error("owner or power bit lies outside the port word");
   end
   if (port_ctl_pkg::ENABLE_BIT > 31 || port_ctl_pkg::CONNECT_BIT > 31) begin : g_stat_place
      $error("status bits lie outside the port word");
   end

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // status bits are masked to zero whenever the port has no power
   function automatic logic power_gated(input logic powered, input logic value);
      return powered & value;
   endfunction

   // ------------------------------------------------------------------
   // pin synchronisers; first stage feeds only the second
   // ------------------------------------------------------------------
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
      end else begin
         sync1_r <= {overcurrent_i, line_dp_i, line_dm_i};
         sync2_r <= sync1_r;
      end
   end

   // ------------------------------------------------------------------
   // configure flag edge; same clock domain, no synchroniser
   // ------------------------------------------------------------------
   // resets low to match the flag's own reset level, so no false rise
   logic flag_prev_r;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         flag_prev_r <= 1'b0;
      end else begin
         flag_prev_r <= configure_flag_i;
      end
   end
   logic flag_rise;
   assign flag_rise = configure_flag_i & ~flag_prev_r; // R5

   // ------------------------------------------------------------------
   // owner bit: flag low forces one, flag rise clears, else software
   // ------------------------------------------------------------------
   logic owner_r;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         owner_r <= port_ctl_pkg::OWNER_RESET; // R4
      end else if (!configure_flag_i) begin
         // a low flag outranks everything, software writes included
         owner_r <= 1'b1; // R4
      end else if (flag_rise) begin
         owner_r <= 1'b0; // R5
      end else if (reg_wr_i.wr) begin
         owner_r <= reg_wr_i.data[port_ctl_pkg::OWNER_BIT]; // R7
      end
   end

   // ------------------------------------------------------------------
   // power bit; overcurrent removal wins over a same-cycle write
   // ------------------------------------------------------------------
   logic power_r;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         power_r <= port_ctl_pkg::POWER_RESET;
      end else if (!POWER_SWITCHES) begin
         power_r <= 1'b1; // R8
      end else if (power_r && sync2_r[2]) begin
         // removal wins, so a write cannot re-power a faulted port this cycle
         power_r <= 1'b0; // R11
      end else if (reg_wr_i.wr) begin
         power_r <= reg_wr_i.data[port_ctl_pkg::POWER_BIT]; // R9
      end
   end
   logic power_eff;
   assign power_eff = POWER_SWITCHES ? power_r : 1'b1; // R8

   // ------------------------------------------------------------------
   // test select field; reserved codes are stored but do nothing
   // ------------------------------------------------------------------
   logic [3:0] test_sel_r;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         test_sel_r <= port_ctl_pkg::TEST_RESET;
      end else if (reg_wr_i.wr) begin
         test_sel_r <= reg_wr_i.data[port_ctl_pkg::TEST_MSB:port_ctl_pkg::TEST_LSB];
      end
   end
   port_ctl_pkg::test_mode_type mode;
   logic reserved_sel;
   test_mode_decode test_mode_decode_i (
      .sel_i(test_sel_r),
      .mode_o(mode),
      .reserved_o(reserved_sel)
   );

   // ------------------------------------------------------------------
   // line state capture; updated only while valid, held otherwise so reads stay stable
   // ------------------------------------------------------------------
   // while enabled the last valid value stays; an unpowered port reads zero
   logic line_ok;
   assign line_ok = power_eff & ~port_enabled_i & connected_i; // R13
   logic [1:0] line_r;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         line_r <= port_ctl_pkg::LINE_SE0;
      end else if (line_ok) begin
         line_r <= {sync2_r[1], sync2_r[0]}; // R12 R13
      end
   end

   // ------------------------------------------------------------------
   // outputs; companion ownership or no power silences our drive
   // ------------------------------------------------------------------
   // transceiver bundle; all fields move on the same edge so they agree
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         drive_o <= '{owned_by_companion: port_ctl_pkg::OWNER_RESET,
                      power_on: port_ctl_pkg::POWER_RESET,
                      drive_enable: 1'b0, test_mode: port_ctl_pkg::MODE_NORMAL};
      end else begin
         drive_o.owned_by_companion <= owner_r; // R6
         drive_o.power_on <= power_eff; // R9
         drive_o.drive_enable <= ~owner_r & power_eff; // R6 R10
         drive_o.test_mode <= mode; // R1 R2
      end
   end

   // power switch drive; held off through reset until the bit is known
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         power_switch_o <= 1'b0;
      end else begin
         power_switch_o <= power_eff; // R9
      end
   end

   // status gate for the change-reporting logic elsewhere in the port
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         status_gate_o <= 1'b0;
      end else begin
         status_gate_o <= power_eff; // R10
      end
   end

   // reserved select flag; visible to test logic, no behaviour attached
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         test_reserved_o <= 1'b0;
      end else begin
         test_reserved_o <= reserved_sel; // R3
      end
   end

   // read image; reserved bits read zero, line state zero when unpowered
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         reg_rd_o <= 32'h0;
      end else begin
         reg_rd_o <= 32'h0;
         reg_rd_o[port_ctl_pkg::TEST_MSB:port_ctl_pkg::TEST_LSB] <= test_sel_r;
         reg_rd_o[port_ctl_pkg::OWNER_BIT] <= owner_r;
         reg_rd_o[port_ctl_pkg::POWER_BIT] <= power_eff; // R8
         reg_rd_o[port_ctl_pkg::LINE_DP_BIT] <= power_gated(power_eff, line_r[1]); // R12
         reg_rd_o[port_ctl_pkg::LINE_DM_BIT] <= power_gated(power_eff, line_r[0]); // R12
         reg_rd_o[port_ctl_pkg::ENABLE_BIT] <= power_gated(power_eff, port_enabled_i); // R10
         reg_rd_o[port_ctl_pkg::CONNECT_BIT] <= power_gated(power_eff, connected_i); // R10
      end
   end
endmodule

// [verif/port_ctl_checker.sv]
// assertions on the port ownership, power and test logic
`timescale 1ns/1ps
module port_ctl_checker #(
   parameter bit POWER_SWITCHES = 1'b1
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire port_ctl_pkg::reg_write_type reg_wr_i,
   input wire logic [31:0] reg_rd_o,
   input wire logic configure_flag_i,
   input wire logic overcurrent_i,
   input wire logic line_dp_i,
   input wire logic line_dm_i,
   input wire logic port_enabled_i,
   input wire logic connected_i,
   input wire port_ctl_pkg::port_drive_type drive_o,
   input wire logic power_switch_o,
   input wire logic status_gate_o,
   input wire logic test_reserved_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // write and flag take two edges to reach the read image
   a_owner_forced_one: assert property (!configure_flag_i |-> ##2 reg_rd_o[13])
      else $error("owner bit not held at one");
   a_flag_rise_clears: assert property ($rose(configure_flag_i) |-> ##2 !reg_rd_o[13])
      else $error("owner bit not cleared by flag rise");
   a_companion_no_drive: assert property (drive_o.owned_by_companion |-> !drive_o.drive_enable)
      else $error("port driven while companion owns it");
   a_always_powered: assert property (!POWER_SWITCHES |-> ##2 power_switch_o)
      else $error("port unpowered without switches");
   a_power_mirror: assert property (reg_rd_o[12] == power_switch_o)
      else $error("power bit and switch disagree");
   a_unpowered_quiet: assert property (!reg_rd_o[12] |-> !reg_rd_o[2] && !reg_rd_o[0])
      else $error("status reported while unpowered");
   a_overcurrent_off: assert property (POWER_SWITCHES && overcurrent_i && power_switch_o
      |-> ##4 !power_switch_o)
      else $error("overcurrent left power on");
   a_line_unpowered: assert property (!reg_rd_o[12] |-> reg_rd_o[11:10] == 2'h0)
      else $error("line state shown while unpowered");
   a_test_decode: assert property (reg_rd_o[19:16] < 4'h6 |->
      drive_o.test_mode == port_ctl_pkg::test_mode_type'(reg_rd_o[18:16]))
      else $error("test mode does not follow select");
   a_test_reserved: assert property (test_reserved_o == (reg_rd_o[19:16] > 4'h5))
      else $error("reserved test flag wrong");
   c_flag_rise: cover property ($rose(configure_flag_i));
   c_overcurrent: cover property (overcurrent_i && power_switch_o);
   c_test_packet: cover property (reg_rd_o[19:16] == 4'h4);
endmodule
bind port_owner_power port_ctl_checker #(.POWER_SWITCHES(POWER_SWITCHES)) port_ctl_checker_i (
   .mclk_i, .rst_n_i, .reg_wr_i, .reg_rd_o, .configure_flag_i, .overcurrent_i, .line_dp_i,
   .line_dm_i, .port_enabled_i, .connected_i, .drive_o, .power_switch_o, .status_gate_o,
   .test_reserved_o);

// [verif/usb_device_model.sv]
// attached device: shows a line state while the port powers it
`timescale 1ns/1ps
module usb_device_model (
   input wire logic power_i,
   input wire logic [1:0] state_i,
   output logic dp_o,
   output logic dm_o,
   output logic conn_o
);
   // unpowered device lets host pull-downs make SE0
   assign conn_o = power_i;
   assign dp_o = power_i & state_i[1];
   assign dm_o = power_i & state_i[0];
endmodule

// [verif/usb_host_port_own_power_line_tb.sv]
// self-checking bench for the port ownership, power and test logic
`timescale 1ns/1ps
module usb_host_port_own_power_line_tb;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   port_ctl_pkg::reg_write_type reg_wr = '0;
   logic cfg = 1'b0;
   logic oc = 1'b0;
   logic [1:0] line_state = 2'h0;
   logic en = 1'b0;
   logic dp, dm, conn, sw, gate, rsv, sw_fixed;
   logic [31:0] rd;
   logic [31:0] rd_fixed;
   port_ctl_pkg::port_drive_type drv;
   int err_count = 0;
   int check_count = 0;
   always #2.5 mclk_i = ~mclk_i;
   usb_device_model usb_device_model_i (.power_i(sw), .state_i(line_state), .dp_o(dp),
      .dm_o(dm), .conn_o(conn));
   // enable driven by the bench so the line state hold can be seen
   port_owner_power port_owner_power_i (.mclk_i, .rst_n_i, .reg_wr_i(reg_wr), .reg_rd_o(rd),
      .configure_flag_i(cfg), .overcurrent_i(oc), .line_dp_i(dp), .line_dm_i(dm),
      .port_enabled_i(en), .connected_i(conn), .drive_o(drv), .power_switch_o(sw),
      .status_gate_o(gate), .test_reserved_o(rsv));
   // second port built without power switches; it shares all stimulus
   port_owner_power #(.POWER_SWITCHES(1'b0)) port_owner_power_fixed_i (.mclk_i, .rst_n_i,
      .reg_wr_i(reg_wr), .reg_rd_o(rd_fixed), .configure_flag_i(cfg), .overcurrent_i(oc),
      .line_dp_i(dp), .line_dm_i(dm), .port_enabled_i(en), .connected_i(conn), .drive_o(),
      .power_switch_o(sw_fixed), .status_gate_o(), .test_reserved_o());
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // reserved bits always written as zero
   task automatic wr(input logic [31:0] d);
      @(negedge mclk_i) reg_wr = {1'b1, d};
      @(negedge mclk_i) reg_wr.wr = 1'b0;
      repeat (2) @(negedge mclk_i);
   endtask
   task automatic end_sim;
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic t_owner;
      chk(rd[13], 1'b1);
      wr(32'h0);
      chk(rd[13], 1'b1);
      @(negedge mclk_i) cfg = 1'b1;
      repeat (3) @(negedge mclk_i);
      chk(rd[13], 1'b0);
      wr(32'h2000);
      chk(drv.owned_by_companion, 1'b1);
      chk(drv.drive_enable, 1'b0);
      @(negedge mclk_i) cfg = 1'b0;
      @(negedge mclk_i) cfg = 1'b1;
      repeat (3) @(negedge mclk_i);
      chk(rd[13], 1'b0);
   endtask
   task automatic t_test;
      for (int c = 0; c < 16; c++) begin
         wr({12'h0, c[3:0], 16'h0});
         chk(drv.test_mode, c < 6 ? c[2:0] : 3'h0);
         chk(rsv, c > 5);
      end
      chk(rd_fixed[12], 1'b1);
      chk(sw_fixed, 1'b1);
   endtask
   task automatic t_power;
      wr(32'h1000);
      chk(sw, 1'b1);
      chk(gate, 1'b1);
      chk(rd[0], 1'b1);
      line_state = port_ctl_pkg::LINE_K;
      repeat (6) @(negedge mclk_i);
      chk(rd[11:10], port_ctl_pkg::LINE_K);
      wr(32'h3000);
      chk(drv.owned_by_companion, 1'b1);
      // enabled port: line state keeps its last valid value
      en = 1'b1;
      line_state = port_ctl_pkg::LINE_J;
      repeat (6) @(negedge mclk_i);
      chk(rd[11:10], port_ctl_pkg::LINE_K);
      chk(rd[2], 1'b1);
      en = 1'b0;
      repeat (6) @(negedge mclk_i);
      chk(rd[11:10], port_ctl_pkg::LINE_J);
      wr(32'h1000);
      chk(drv.owned_by_companion, 1'b0);
      chk(drv.drive_enable, 1'b1);
      oc = 1'b1;
      repeat (5) @(negedge mclk_i);
      oc = 1'b0;
      chk(sw, 1'b0);
      chk(gate, 1'b0);
      chk(rd[0], 1'b0);
      chk(rd[11:10], 2'h0);
      chk(sw_fixed, 1'b1);
      chk(rd_fixed[12], 1'b1);
   endtask
   // mid-run reset with the flag cleared, as a controller reset leaves it
   task automatic t_reset;
      cfg = 1'b0;
      rst_n_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      rst_n_i = 1'b1;
      repeat (2) @(negedge mclk_i);
      chk(rd[13], 1'b1);
      chk(rd[12], 1'b0);
      chk(sw, 1'b0);
      chk(rd_fixed[12], 1'b1);
   endtask
   initial begin
      repeat (2) @(negedge mclk_i);
      rst_n_i = 1'b1;
      repeat (3) @(negedge mclk_i);
      t_owner;
      t_test;
      t_power;
      t_reset;
      end_sim;
   end
   // whole run needs well under 400 cycles
   initial begin
      #20us;
      err_count++;
      end_sim;
   end
endmodule
